// ---- common/rmp_link_if.sv ----
`timescale 1ns/100ps
interface rmp_link_if;
  logic bm_we;
  logic bm_re;
  logic [11:0] bm_addr;
  logic [15:0] bm_wdata;
  logic [15:0] bm_rdata;
  logic bm_rvalid;
  logic print_req;
  logic print_pause;
  logic print_done;

  modport dev
  (
    input bm_we,
    input bm_re,
    input bm_addr,
    input bm_wdata,
    output bm_rdata,
    output bm_rvalid,
    input print_req,
    input print_pause,
    output print_done
  );

  modport host
  (
    output bm_we,
    output bm_re,
    output bm_addr,
    output bm_wdata,
    input bm_rdata,
    input bm_rvalid,
    output print_req,
    output print_pause,
    input print_done
  );
endinterface

// ---- common/rmp_pkg.sv ----
package rmp_pkg;
  // ----------------------------------------------------------------
  // buffer memory map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_FUNC = 12'h800;
  localparam logic [11:0] ADDR_ERR = 12'h801;
  localparam logic [11:0] ADDR_OPT = 12'h820;
  localparam logic [11:0] ADDR_PTR = 12'h821;
  localparam logic [11:0] ADDR_CNT = 12'h822;
  localparam logic [11:0] ADDR_LIST = 12'h823;
  localparam logic [11:0] ADDR_LIST_END = 12'h887;
  localparam int LIST_MAX = 100;
  // ----------------------------------------------------------------
  // values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] FUNC_MSG_OUT = 16'h0003;
  localparam logic [15:0] OPT_CRLF_ON = 16'h0001;
  localparam logic [15:0] PTR_MAX = 16'h0063;
  localparam logic [15:0] CNT_MAX = 16'h0064;
  localparam logic [15:0] FIXED_MIN = 16'h0001;
  localparam logic [15:0] FIXED_MAX = 16'h0190;
  localparam int FREE_BIT = 15;
  localparam logic [14:0] FREE_MIN = 15'h0001;
  localparam logic [14:0] FREE_MAX = 15'h001F;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_LF = 8'h0A;
  localparam logic [7:0] CHR_END = 8'h00;
  localparam logic [6:0] MSG_LEN = 7'h50;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_FUNC = 16'h00F1;
  localparam logic [15:0] ERR_RANGE = 16'h00F2;
endpackage

// ---- logic/rmp_dev.sv ----
`timescale 1ns/100ps
// Functional notes
// - one run sends up to 100 listed messages
// - host writes function code 3 first
// - option 1 appends CR LF after messages not already ending in CR LF
// - start index 0..99 picks first entry
// - count 1..100 consecutive entries are sent
// - messages go out in list order
// - entries 0001H..0190H are fixed messages
// - bit 15 set marks free message 1..31
// - host raises request after writing schedule
// - host drops request, then reads result
// - host clears nonzero result by writing zero
// - pause holds sending, resumes where stopped
// - function word lives at 800H
// - result word at 801H, zero is success
// - completion raised when function finishes
// - uncleared error refuses new functions
module rmp_dev
(
  input wire logic clk,
  input wire logic rst_b,
  rmp_link_if.dev link,
  output logic [15:0] msg_id,
  output logic [6:0] msg_idx,
  input wire logic [7:0] msg_char,
  output logic prn_valid,
  output logic [7:0] prn_data,
  input wire logic prn_ready
);
  typedef enum {ST_IDLE, ST_CHECK, ST_SCAN, ST_LOAD, ST_SEND, ST_CR, ST_LF, ST_NEXT,
    ST_DONE} rmp_dev_state_t;
  rmp_dev_state_t state_q;
  logic [15:0] func_q, err_q, opt_q, ptr_q, cnt_q, rdata_q, msg_q;
  logic [15:0] list_q [rmp_pkg::LIST_MAX];
  logic rvalid_q, done_q, valid_q;
  logic [6:0] idx_q, rem_q, chr_q;
  logic [7:0] last_q, prev_q, data_q;
  logic err_set, slot_free;
  logic [15:0] err_code, entry;
  // the last area word has no list slot behind it
  function automatic logic in_list(input logic [11:0] a);
    in_list = (a >= rmp_pkg::ADDR_LIST) && (a <= rmp_pkg::ADDR_LIST_END)
      && (12'(a - rmp_pkg::ADDR_LIST) < 12'(rmp_pkg::LIST_MAX));
  endfunction
  function automatic logic [6:0] list_ix(input logic [11:0] a);
    list_ix = 7'(a - rmp_pkg::ADDR_LIST);
  endfunction
  function automatic logic entry_ok(input logic [15:0] e);
    if (e[rmp_pkg::FREE_BIT])
      entry_ok = (e[14:0] >= rmp_pkg::FREE_MIN) && (e[14:0] <= rmp_pkg::FREE_MAX);
    else
      entry_ok = (e >= rmp_pkg::FIXED_MIN) && (e <= rmp_pkg::FIXED_MAX);
  endfunction
  assign entry = list_q[idx_q];
  // pause only blocks the next character; one already offered still drains
  assign slot_free = !valid_q && !link.print_pause;
  // ----------------------------------------------------------------
  // buffer memory words, written and read by the host
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      func_q <= rmp_pkg::WORD_RESET;
      opt_q <= rmp_pkg::WORD_RESET;
      ptr_q <= rmp_pkg::WORD_RESET;
      cnt_q <= rmp_pkg::WORD_RESET;
    end
    else if (link.bm_we)
    begin
      case (link.bm_addr)
        rmp_pkg::ADDR_FUNC: func_q <= link.bm_wdata;
        rmp_pkg::ADDR_OPT: opt_q <= link.bm_wdata;
        rmp_pkg::ADDR_PTR: ptr_q <= link.bm_wdata;
        rmp_pkg::ADDR_CNT: cnt_q <= link.bm_wdata;
        default: ;
      endcase
    end
  end
  generate
    for (genvar i = 0; i < rmp_pkg::LIST_MAX; i++)
    begin : g_list
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          list_q[i] <= rmp_pkg::WORD_RESET;
        else if (link.bm_we && in_list(link.bm_addr) && list_ix(link.bm_addr) == 7'(i))
          list_q[i] <= link.bm_wdata;
      end
    end
  endgenerate
  // result word: device report wins over a host clear in one cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      err_q <= rmp_pkg::ERR_NONE;
    else if (err_set)
      err_q <= err_code;
    else if (link.bm_we && link.bm_addr == rmp_pkg::ADDR_ERR)
      err_q <= link.bm_wdata;
  end
  // host reads, answered one cycle later
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= rmp_pkg::WORD_RESET;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= link.bm_re;
      if (link.bm_re)
      begin
        case (link.bm_addr)
          rmp_pkg::ADDR_FUNC: rdata_q <= func_q;
          rmp_pkg::ADDR_ERR: rdata_q <= err_q;
          rmp_pkg::ADDR_OPT: rdata_q <= opt_q;
          rmp_pkg::ADDR_PTR: rdata_q <= ptr_q;
          rmp_pkg::ADDR_CNT: rdata_q <= cnt_q;
          default: rdata_q <= in_list(link.bm_addr) ? list_q[list_ix(link.bm_addr)]
            : rmp_pkg::WORD_RESET;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // sequencer and error detection
  // ----------------------------------------------------------------
  always_comb
  begin
    err_set = 1'b0;
    err_code = rmp_pkg::ERR_NONE;
    if (state_q == ST_CHECK)
    begin
      if (func_q != rmp_pkg::FUNC_MSG_OUT)
      begin
        err_set = 1'b1;
        err_code = rmp_pkg::ERR_FUNC;
      end
      else if (ptr_q > rmp_pkg::PTR_MAX || cnt_q == 16'h0000 || cnt_q > rmp_pkg::CNT_MAX
        || ({1'b0, ptr_q} + {1'b0, cnt_q}) > {1'b0, rmp_pkg::CNT_MAX})
      begin
        err_set = 1'b1;
        err_code = rmp_pkg::ERR_RANGE;
      end
    end
    else if (state_q == ST_SCAN && !entry_ok(entry))
    begin
      err_set = 1'b1;
      err_code = rmp_pkg::ERR_RANGE;
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      done_q <= 1'b0;
      idx_q <= 7'h00;
      rem_q <= 7'h00;
      chr_q <= 7'h00;
      last_q <= 8'h00;
      prev_q <= 8'h00;
      msg_q <= rmp_pkg::WORD_RESET;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (link.print_req)
            state_q <= (err_q != rmp_pkg::ERR_NONE) ? ST_DONE : ST_CHECK;
        ST_CHECK:
        begin
          idx_q <= ptr_q[6:0];
          rem_q <= cnt_q[6:0];
          state_q <= err_set ? ST_DONE : ST_SCAN;
        end
        ST_SCAN:
          if (err_set)
            state_q <= ST_DONE;
          else if (rem_q == 7'h01)
          begin
            idx_q <= ptr_q[6:0];
            rem_q <= cnt_q[6:0];
            state_q <= ST_LOAD;
          end
          else
          begin
            idx_q <= idx_q + 7'h01;
            rem_q <= rem_q - 7'h01;
          end
        ST_LOAD:
        begin
          msg_q <= entry;
          chr_q <= 7'h00;
          last_q <= 8'h00;
          prev_q <= 8'h00;
          state_q <= ST_SEND;
        end
        ST_SEND:
          if (slot_free)
          begin
            if (msg_char == rmp_pkg::CHR_END || chr_q == rmp_pkg::MSG_LEN)
            begin
              if (opt_q == rmp_pkg::OPT_CRLF_ON
                && !(prev_q == rmp_pkg::CHR_CR && last_q == rmp_pkg::CHR_LF))
                state_q <= ST_CR;
              else
                state_q <= ST_NEXT;
            end
            else
            begin
              chr_q <= chr_q + 7'h01;
              prev_q <= last_q;
              last_q <= msg_char;
            end
          end
        ST_CR, ST_LF:
          if (slot_free)
            state_q <= (state_q == ST_CR) ? ST_LF : ST_NEXT;
        ST_NEXT:
          if (rem_q != 7'h01)
          begin
            idx_q <= idx_q + 7'h01;
            rem_q <= rem_q - 7'h01;
            state_q <= ST_LOAD;
          end
          else if (!valid_q)
            state_q <= ST_DONE;
        ST_DONE:
        begin
          done_q <= link.print_req;
          if (!link.print_req)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      valid_q <= 1'b0;
      data_q <= 8'h00;
    end
    else if (valid_q)
      valid_q <= !prn_ready;
    else if (slot_free)
    begin
      case (state_q)
        ST_SEND:
          if (msg_char != rmp_pkg::CHR_END && chr_q != rmp_pkg::MSG_LEN)
          begin
            valid_q <= 1'b1;
            data_q <= msg_char;
          end
        ST_CR, ST_LF:
        begin
          valid_q <= 1'b1;
          data_q <= (state_q == ST_CR) ? rmp_pkg::CHR_CR : rmp_pkg::CHR_LF;
        end
        default: ;
      endcase
    end
  end
  assign link.bm_rdata = rdata_q;
  assign link.bm_rvalid = rvalid_q;
  assign link.print_done = done_q;
  assign msg_id = msg_q;
  assign msg_idx = chr_q;
  assign prn_valid = valid_q;
  assign prn_data = data_q;
endmodule

// ---- logic/rmp_host.sv ----
`timescale 1ns/100ps
module rmp_host
(
  input wire logic clk,
  input wire logic rst_b,
  rmp_link_if.host link,
  input wire logic usr_wr,
  input wire logic [11:0] usr_addr,
  input wire logic [15:0] usr_wdata,
  input wire logic usr_start,
  input wire logic usr_pause,
  output logic usr_ready,
  output logic usr_done,
  output logic [15:0] usr_err
);
  typedef enum {HS_IDLE, HS_FUNC, HS_REQ, HS_WAIT, HS_READ, HS_RWAIT, HS_CLEAR,
    HS_FIN} rmp_host_state_t;

  rmp_host_state_t state_q;
  logic we_q;
  logic re_q;
  logic [11:0] addr_q;
  logic [15:0] wdata_q;
  logic req_q;
  logic pause_q;
  logic done_q;
  logic [15:0] err_q;

  assign usr_ready = (state_q == HS_IDLE);

  // ----------------------------------------------------------------
  // request sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= HS_IDLE;
      we_q <= 1'b0;
      re_q <= 1'b0;
      addr_q <= 12'h000;
      wdata_q <= rmp_pkg::WORD_RESET;
      req_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= rmp_pkg::ERR_NONE;
    end
    else
    begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        HS_IDLE:
          if (usr_wr)
          begin
            we_q <= 1'b1;
            addr_q <= usr_addr;
            wdata_q <= usr_wdata;
          end
          else if (usr_start)
          begin
            we_q <= 1'b1;
            addr_q <= rmp_pkg::ADDR_FUNC;
            wdata_q <= rmp_pkg::FUNC_MSG_OUT;
            state_q <= HS_FUNC;
          end
        HS_FUNC:
          state_q <= HS_REQ;
        HS_REQ:
        begin
          req_q <= 1'b1;
          state_q <= HS_WAIT;
        end
        HS_WAIT:
          if (link.print_done)
          begin
            req_q <= 1'b0;
            state_q <= HS_READ;
          end
        HS_READ:
        begin
          re_q <= 1'b1;
          addr_q <= rmp_pkg::ADDR_ERR;
          state_q <= HS_RWAIT;
        end
        HS_RWAIT:
          if (link.bm_rvalid)
          begin
            err_q <= link.bm_rdata;
            state_q <= (link.bm_rdata != rmp_pkg::ERR_NONE) ? HS_CLEAR : HS_FIN;
          end
        HS_CLEAR:
        begin
          we_q <= 1'b1;
          addr_q <= rmp_pkg::ADDR_ERR;
          wdata_q <= rmp_pkg::ERR_NONE;
          state_q <= HS_FIN;
        end
        HS_FIN:
        begin
          done_q <= 1'b1;
          state_q <= HS_IDLE;
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pause_q <= 1'b0;
    else
      pause_q <= usr_pause;
  end

  assign link.bm_we = we_q;
  assign link.bm_re = re_q;
  assign link.bm_addr = addr_q;
  assign link.bm_wdata = wdata_q;
  assign link.print_req = req_q;
  assign link.print_pause = pause_q;
  assign usr_done = done_q;
  assign usr_err = err_q;
endmodule

// ---- test/registered_message_print_scheduler_test.sv ----
`timescale 1ns/100ps
module registered_message_print_scheduler_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic usr_wr = 1'b0;
  logic usr_start = 1'b0;
  logic usr_pause = 1'b0;
  logic prn_ready = 1'b0;
  logic [11:0] usr_addr = 12'h000;
  logic [15:0] usr_wdata = 16'h0000;
  logic usr_ready, usr_done, prn_valid;
  logic [15:0] usr_err, msg_id;
  logic [6:0] msg_idx;
  logic [7:0] prn_data, msg_char;
  logic [15:0] lst [100];
  logic [15:0] bad [4] = '{16'h0000, 16'h0191, 16'h8000, 16'h8020};
  logic [15:0] ex [5] = '{16'h0001, 16'h8005, 16'h0002, 16'h8006, 16'h0003};
  logic [7:0] rx [$];
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  rmp_link_if link();
  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // message store and printer
  // ----------------------------------------------------------------
  // fixed message 1 is a full 80 characters with no end mark
  function automatic logic [7:0] chr(logic [15:0] id, logic [6:0] i);
    if (i >= ((id == 16'h0001) ? 7'h50 : 7'h03))
      return 8'h00;
    return (i == 7'h00) ? 8'h40 + {3'h0, id[4:0]} + (id[15] ? 8'h20 : 8'h00) : 8'h2E;
  endfunction
  assign msg_char = chr(msg_id, msg_idx);

  // printer stalls one cycle in four
  always @(posedge clk)
  begin
    cyc++;
    prn_ready <= cyc[1:0] != 2'h3;
    if (prn_valid && prn_ready)
      rx.push_back(prn_data);
    if (cyc == 40000)
    begin
      n_errors++;
      summarize();
    end
  end

  rmp_dev rmp_dev_i (.clk(clk), .rst_b(rst_b), .link(link), .msg_id(msg_id),
    .msg_idx(msg_idx), .msg_char(msg_char), .prn_valid(prn_valid), .prn_data(prn_data),
    .prn_ready(prn_ready));
  rmp_host rmp_host_i (.clk(clk), .rst_b(rst_b), .link(link), .usr_wr(usr_wr),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_start(usr_start),
    .usr_pause(usr_pause), .usr_ready(usr_ready), .usr_done(usr_done), .usr_err(usr_err));
  rmp_link_sva sva_i (.clk(clk), .rst_b(rst_b), .bm_we(link.bm_we), .bm_re(link.bm_re),
    .bm_addr(link.bm_addr), .bm_wdata(link.bm_wdata), .bm_rdata(link.bm_rdata),
    .bm_rvalid(link.bm_rvalid), .print_req(link.print_req),
    .print_pause(link.print_pause), .print_done(link.print_done));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    while (usr_ready !== 1'b1)
      @(posedge clk);
    usr_wr <= 1'b1;
    usr_addr <= a;
    usr_wdata <= d;
    @(posedge clk);
    usr_wr <= 1'b0;
  endtask

  task automatic setl(input int i, input logic [15:0] v);
    lst[i] = v;
    wr(rmp_pkg::ADDR_LIST + 12'(i), v);
  endtask

  task automatic run(input logic [15:0] opt, ptr, cnt, xerr, input bit pz);
    logic [7:0] e [$];
    int n;
    wr(rmp_pkg::ADDR_OPT, opt);
    wr(rmp_pkg::ADDR_PTR, ptr);
    wr(rmp_pkg::ADDR_CNT, cnt);
    rx.delete();
    @(posedge clk);
    usr_start <= 1'b1;
    @(posedge clk);
    usr_start <= 1'b0;
    if (pz)
    begin
      while (rx.size() < 5)
        @(posedge clk);
      usr_pause <= 1'b1;
      n = rx.size();
      repeat (30) @(posedge clk);
      chk("paused bytes", 16'(rx.size() - n > 2), 16'h0000);
      usr_pause <= 1'b0;
    end
    n = 0;
    do @(posedge clk); while (usr_done !== 1'b1 && ++n < 30000);
    chk("done seen", 16'(n < 30000), 16'h0001);
    chk("result", usr_err, xerr);
    for (int k = 0; k < cnt && xerr == 16'h0000; k++)
    begin
      for (int j = 0; j < 80 && chr(lst[ptr + k], 7'(j)) != 8'h00; j++)
        e.push_back(chr(lst[ptr + k], 7'(j)));
      if (opt == rmp_pkg::OPT_CRLF_ON)
      begin
        e.push_back(rmp_pkg::CHR_CR);
        e.push_back(rmp_pkg::CHR_LF);
      end
    end
    chk("byte count", 16'(rx.size()), 16'(e.size()));
    foreach (e[i])
      chk("byte", {8'h00, rx[i]}, {8'h00, e[i]});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    setl(0, 16'h0001);
    run(16'h0000, 16'h0000, 16'h0000, rmp_pkg::ERR_RANGE, 1'b0);
    run(16'h0000, 16'h0000, 16'h0065, rmp_pkg::ERR_RANGE, 1'b0);
    run(16'h0000, 16'h0064, 16'h0001, rmp_pkg::ERR_RANGE, 1'b0);
    run(16'h0000, 16'h0063, 16'h0002, rmp_pkg::ERR_RANGE, 1'b0);
    foreach (bad[i])
    begin
      setl(0, bad[i]);
      run(16'h0000, 16'h0000, 16'h0001, rmp_pkg::ERR_RANGE, 1'b0);
    end
    // a clean run after errors shows the host cleared them
    foreach (ex[i])
      setl(10 + i, ex[i]);
    // a code left in the result word must block the run and come back unchanged
    wr(rmp_pkg::ADDR_ERR, rmp_pkg::ERR_FUNC);
    run(16'h0000, 16'h000A, 16'h0005, rmp_pkg::ERR_FUNC, 1'b0);
    run(16'h0000, 16'h000A, 16'h0005, rmp_pkg::ERR_NONE, 1'b0);
    setl(0, 16'h8001);
    setl(1, 16'h0001);
    run(16'h0001, 16'h0000, 16'h0002, rmp_pkg::ERR_NONE, 1'b1);
    for (int i = 0; i < 100; i++)
      setl(i, (i == 0) ? 16'h0190 : (i == 99) ? 16'h801F : 16'h0100 + 16'(i));
    run(16'h0000, 16'h0000, 16'h0064, rmp_pkg::ERR_NONE, 1'b0);
    run(16'h0001, 16'h0063, 16'h0001, rmp_pkg::ERR_NONE, 1'b0);
    summarize();
  end
endmodule

// ---- test/rmp_link_sva.sv ----
`timescale 1ns/100ps
module rmp_link_sva
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bm_we,
  input wire logic bm_re,
  input wire logic [11:0] bm_addr,
  input wire logic [15:0] bm_wdata,
  input wire logic [15:0] bm_rdata,
  input wire logic bm_rvalid,
  input wire logic print_req,
  input wire logic print_pause,
  input wire logic print_done
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // buffer bus
  // ----------------------------------------------------------------
  read_latency_a: assert property (bm_re |=> bm_rvalid)
    else $error("read answer not one cycle after read");
  read_hold_a: assert property (!bm_rvalid |-> $stable(bm_rdata))
    else $error("read data moved without a read");
  // ----------------------------------------------------------------
  // request and completion
  // ----------------------------------------------------------------
  func_first_a: assert property ($rose(print_req) |-> $past(bm_we, 2) &&
    $past(bm_addr, 2) == rmp_pkg::ADDR_FUNC && $past(bm_wdata, 2) == rmp_pkg::FUNC_MSG_OUT)
    else $error("request raised without function code write");
  done_cause_a: assert property ($rose(print_done) |-> print_req)
    else $error("completion without request");
  done_min_a: assert property ($rose(print_req) |-> !print_done ##1 !print_done)
    else $error("completion too early");
  done_hold_a: assert property (print_done && print_req |=> print_done)
    else $error("completion dropped while requested");
  done_drop_a: assert property (print_done && !print_req |=> !print_done)
    else $error("completion held after request fell");
  result_read_a: assert property ($fell(print_req) |-> $past(print_done) ##[1:6]
    (bm_re && bm_addr == rmp_pkg::ADDR_ERR))
    else $error("result word not read after request fell");
  err_clear_a: assert property (bm_rvalid && bm_rdata != 16'h0000 &&
    $past(bm_addr) == rmp_pkg::ADDR_ERR |-> ##[1:4]
    (bm_we && bm_addr == rmp_pkg::ADDR_ERR && bm_wdata == 16'h0000))
    else $error("nonzero result not cleared");
  cover property ($rose(print_done));
  cover property (print_pause && print_req);
  cover property (bm_rvalid && bm_rdata != 16'h0000);
endmodule
